/* rtl/tone_timer_and_wakeup_control.sv */
module tone_timer_and_wakeup_control
    import tone_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wr_strobe,
    input wire logic [SEL_W-1:0] i_wr_sel,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_instr_stop,
    input wire logic i_instr_hold,
    input wire logic i_irq_enable_instr,
    input wire logic i_irq_mask_instr,
    input wire logic i_return_instr,
    input wire logic i_irq_ack,
    input wire logic i_div0_overflow,
    input wire logic i_div1_overflow,
    input wire logic i_interval_underflow,
    input wire logic i_dual_clock_slow,
    input wire logic i_waveform_gen,
    input wire logic i_sub_osc_clock,
    input wire logic [PIN_W-1:0] i_wake_input_port,
    output logic o_tone_output_pin,
    output logic o_irq_request,
    output logic [VEC_W-1:0] o_irq_vector,
    output logic o_core_run,
    output logic o_main_osc_enable,
    output logic o_interval_clock_div,
    output logic o_interval_run,
    output logic [FLAG_W-1:0] o_event_flags,
    output logic [FLAG_W-1:0] o_hold_cause_flags
);
    logic [PIN_W:0] sync_out;
    logic sub_sync;
    logic [PIN_W-1:0] port_sync;

    sync2 #(.WIDTH(PIN_W + 1)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({i_sub_osc_clock, i_wake_input_port}),
        .o_sync(sync_out)
    );
    assign sub_sync = sync_out[PIN_W];
    assign port_sync = sync_out[PIN_W-1:0];

    // Timer group state
    logic [DATA_W-1:0] tone_ctrl_reg, tone_ctrl_next;
    logic [DATA_W-1:0] interval_ctrl_reg, interval_ctrl_next;
    logic [COUNT_W-1:0] reload_reg, reload_next;
    logic [COUNT_W-1:0] tone_count_reg, tone_count_next;
    logic [PRESCALE_W-1:0] presc_reg, presc_next;
    logic sub_prev_reg, sub_prev_next;
    logic toggle_reg, toggle_next;
    logic pin_reg, pin_next;

    // Control group state
    power_mode_e state_reg, state_next;
    logic [FLAG_W-1:0] evf_reg, evf_next;
    logic [FLAG_W-1:0] ief_reg, ief_next;
    logic [FLAG_W-1:0] hef_reg, hef_next;
    logic [FLAG_W-1:0] hcf_reg, hcf_next;
    logic [PIN_W-1:0] sef_reg, sef_next;
    logic [PIN_W-1:0] pef_reg, pef_next;
    logic [PIN_W-1:0] port_prev_reg, port_prev_next;
    logic gie_reg, gie_next;
    logic irq_reg, irq_next;
    logic [2:0] idx_reg, idx_next;
    logic [VEC_W-1:0] vec_reg, vec_next;
    logic main_off_reg, main_off_next;
    logic run_reg, run_next;
    logic osc_reg, osc_next;

    logic stopped, tone_tick, tone_active, tone_uf, tone_start;
    logic wake_fall;
    logic [FLAG_W-1:0] ev_set, ev_clr, release_ev, pending;

    function automatic logic wr(input logic [SEL_W-1:0] sel);
        wr = i_wr_strobe && (i_wr_sel == sel);
    endfunction

    // Hold cause layout differs from event layout for the tone timer
    function automatic logic [FLAG_W-1:0] to_hcf(input logic [FLAG_W-1:0] v);
        to_hcf = v & 8'h17;
        to_hcf[HCF_TONE_BIT] = v[EV_TONE];
    endfunction

    function automatic logic [VEC_W-1:0] vector_of(input logic [2:0] idx);
        case (idx)
            EV_DIV0: vector_of = VEC_DIV0;
            EV_INTERVAL: vector_of = VEC_INTERVAL;
            EV_PORT: vector_of = VEC_PORT;
            EV_DIV1: vector_of = VEC_DIV1;
            EV_TONE: vector_of = VEC_TONE;
            default: vector_of = VEC_DIV0;
        endcase
    endfunction

    assign stopped = (state_reg == PM_STOP);
    // Sub clock edge taken from second sync stage only
    assign tone_tick = tone_ctrl_reg[TONE_SUB_BIT] ?
        (sub_sync & ~sub_prev_reg) :
        (tone_ctrl_reg[TONE_DIV_BIT] ? (presc_reg == PRESCALE_LAST) : 1'b1);
    // Hold does not gate the timer, only stop does
    assign tone_active = tone_ctrl_reg[RUN_BIT] & ~stopped;
    assign tone_uf = tone_active & tone_tick &
        (tone_count_reg == COUNT_ZERO);
    assign tone_start = wr(SEL_TONE_CTRL) & i_wr_data[RUN_BIT] &
        ~tone_ctrl_reg[RUN_BIT];
    assign wake_fall = |(port_prev_reg & ~port_sync & sef_reg);

    always_comb
    begin
        tone_ctrl_next = tone_ctrl_reg;
        interval_ctrl_next = interval_ctrl_reg;
        reload_next = reload_reg;
        tone_count_next = tone_count_reg;
        presc_next = presc_reg + 1'b1;
        sub_prev_next = sub_sync;
        toggle_next = toggle_reg;
        if (wr(SEL_TONE_CTRL))
        begin
            tone_ctrl_next = i_wr_data;
        end
        if (wr(SEL_INTERVAL_CTRL))
        begin
            interval_ctrl_next = i_wr_data;
        end
        if (wr(SEL_PRESET_LO))
        begin
            reload_next[3:0] = i_wr_data;
        end
        if (wr(SEL_PRESET_HI))
        begin
            reload_next[7:4] = i_wr_data;
        end
        if (tone_start)
        begin
            tone_count_next = reload_reg;
        end
        else if (tone_active && tone_tick)
        begin
            // Period is preset plus one ticks
            if (tone_count_reg == COUNT_ZERO)
            begin
                tone_count_next = reload_reg;
            end
            else
            begin
                tone_count_next = tone_count_reg - 1'b1;
            end
        end
        if (tone_uf)
        begin
            toggle_next = ~toggle_reg;
        end
        if (stopped)
        begin
            pin_next = 1'b1;
        end
        else if (tone_ctrl_reg[TONE_PIN_BIT])
        begin
            pin_next = toggle_reg;
        end
        else
        begin
            pin_next = i_waveform_gen;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            tone_ctrl_reg <= CTRL_RESET;
            interval_ctrl_reg <= CTRL_RESET;
            reload_reg <= COUNT_ZERO;
            tone_count_reg <= COUNT_ZERO;
            presc_reg <= '0;
            sub_prev_reg <= 1'b0;
            toggle_reg <= 1'b0;
            pin_reg <= 1'b0;
        end
        else
        begin
            tone_ctrl_reg <= tone_ctrl_next;
            interval_ctrl_reg <= interval_ctrl_next;
            reload_reg <= reload_next;
            tone_count_reg <= tone_count_next;
            presc_reg <= presc_next;
            sub_prev_reg <= sub_prev_next;
            toggle_reg <= toggle_next;
            pin_reg <= pin_next;
        end
    end

    always_comb
    begin
        ev_set = FLAGS_RESET;
        ev_set[EV_DIV0] = i_div0_overflow;
        ev_set[EV_INTERVAL] = i_interval_underflow;
        ev_set[EV_PORT] = |((port_sync ^ port_prev_reg) & pef_reg);
        ev_set[EV_DIV1] = i_div1_overflow;
        ev_set[EV_TONE] = tone_uf;
        ev_clr = FLAGS_RESET;
        if (i_irq_ack)
        begin
            ev_clr[idx_reg] = 1'b1;
        end
        if (wr(SEL_EVF_CLR_LO))
        begin
            ev_clr[3:0] = ev_clr[3:0] | i_wr_data;
        end
        if (wr(SEL_EVF_CLR_HI))
        begin
            ev_clr[7:4] = ev_clr[7:4] | i_wr_data;
        end
        if (tone_start)
        begin
            ev_clr[EV_TONE] = 1'b1;
        end
        // Set beats clear in the same cycle
        evf_next = ((evf_reg & ~ev_clr) | ev_set) & EVENT_MASK;
        ief_next = ief_reg;
        hef_next = hef_reg;
        sef_next = wr(SEL_STOP_WAKE) ? i_wr_data : sef_reg;
        pef_next = wr(SEL_PIN_EN) ? i_wr_data : pef_reg;
        if (wr(SEL_IRQ_EN_LO))
        begin
            ief_next[3:0] = i_wr_data;
        end
        if (wr(SEL_IRQ_EN_HI))
        begin
            ief_next[7:4] = i_wr_data;
        end
        if (wr(SEL_HOLD_EN_LO))
        begin
            hef_next[3:0] = i_wr_data;
        end
        if (wr(SEL_HOLD_EN_HI))
        begin
            hef_next[7:4] = i_wr_data;
        end
        ief_next = ief_next & EVENT_MASK;
        hef_next = hef_next & EVENT_MASK;
        port_prev_next = port_sync;
        release_ev = ev_set & hef_reg;
        hcf_next = hcf_reg & ~to_hcf(ev_clr);
        if (wr(SEL_HOLD_EN_LO) || wr(SEL_HOLD_EN_HI))
        begin
            hcf_next = hcf_next & to_hcf(hef_next);
        end
        if (state_reg == PM_HOLD || state_reg == PM_HOLD_ISR)
        begin
            hcf_next = hcf_next | to_hcf(release_ev);
        end
        pending = evf_reg & ief_reg;
        gie_next = gie_reg;
        if (i_irq_ack || i_irq_mask_instr)
        begin
            gie_next = 1'b0;
        end
        if (i_irq_enable_instr || wr(SEL_IRQ_EN_LO) || wr(SEL_IRQ_EN_HI))
        begin
            gie_next = 1'b1;
        end
        irq_next = gie_reg & (|pending) & ~stopped & ~i_irq_ack;
        idx_next = idx_reg;
        for (int i = FLAG_W - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                idx_next = 3'(i);
            end
        end
        vec_next = vector_of(idx_next);
        main_off_next = main_off_reg;
        if (wake_fall)
        begin
            main_off_next = 1'b0;
        end
        state_next = state_reg;
        case (state_reg)
            PM_RUN:
            begin
                if (i_instr_stop && i_dual_clock_slow)
                begin
                    main_off_next = 1'b1;
                end
                else if (i_instr_stop)
                begin
                    state_next = PM_STOP;
                end
                else if (i_instr_hold && hcf_reg == FLAGS_RESET)
                begin
                    state_next = PM_HOLD;
                end
            end
            PM_HOLD:
            begin
                if (|release_ev)
                begin
                    state_next = PM_RUN;
                end
                else if (irq_reg)
                begin
                    state_next = PM_HOLD_ISR;
                end
            end
            PM_HOLD_ISR:
            begin
                if (i_return_instr)
                begin
                    state_next = (hcf_next == FLAGS_RESET) ?
                        PM_HOLD : PM_RUN;
                end
            end
            PM_STOP:
            begin
                if (wake_fall)
                begin
                    state_next = PM_RUN;
                end
            end
            default:
            begin
                state_next = PM_RUN;
            end
        endcase
        run_next = (state_next == PM_RUN) || (state_next == PM_HOLD_ISR);
        // Registered so the main oscillator enable output carries no decode glitch
        osc_next = ~main_off_next & (state_next != PM_STOP);
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= PM_RUN;
            evf_reg <= FLAGS_RESET;
            ief_reg <= FLAGS_RESET;
            hef_reg <= FLAGS_RESET;
            hcf_reg <= FLAGS_RESET;
            sef_reg <= CTRL_RESET;
            pef_reg <= CTRL_RESET;
            port_prev_reg <= CTRL_RESET;
            gie_reg <= 1'b1;
            irq_reg <= 1'b0;
            idx_reg <= EV_DIV0;
            vec_reg <= VEC_DIV0;
            main_off_reg <= 1'b0;
            run_reg <= 1'b1;
            osc_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            evf_reg <= evf_next;
            ief_reg <= ief_next;
            hef_reg <= hef_next;
            hcf_reg <= hcf_next;
            sef_reg <= sef_next;
            pef_reg <= pef_next;
            port_prev_reg <= port_prev_next;
            gie_reg <= gie_next;
            irq_reg <= irq_next;
            idx_reg <= idx_next;
            vec_reg <= vec_next;
            main_off_reg <= main_off_next;
            run_reg <= run_next;
            osc_reg <= osc_next;
        end
    end

    assign o_tone_output_pin = pin_reg;
    assign o_irq_request = irq_reg;
    assign o_irq_vector = vec_reg;
    assign o_core_run = run_reg;
    assign o_main_osc_enable = osc_reg;
    assign o_interval_clock_div = interval_ctrl_reg[INTERVAL_DIV_BIT];
    assign o_interval_run = interval_ctrl_reg[RUN_BIT];
    assign o_event_flags = evf_reg;
    assign o_hold_cause_flags = hcf_reg;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence s_stop_wake;
        (state_reg == PM_STOP) && wake_fall;
    endsequence
    sequence s_isr_return_idle;
        (state_reg == PM_HOLD_ISR) && i_return_instr &&
            (hcf_next == FLAGS_RESET);
    endsequence

    property p_underflow_flag;
        tone_uf |=> evf_reg[EV_TONE] && tone_count_reg == $past(reload_reg);
    endproperty
    a_underflow_flag: assert property (p_underflow_flag)
        else $error("underflow did not set flag or reload");

    property p_start_load;
        tone_start |=> tone_count_reg == $past(reload_reg) &&
            !evf_reg[EV_TONE] && tone_ctrl_reg[RUN_BIT];
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("start did not load counter or clear flag");

    property p_preset_keeps_count;
        (wr(SEL_PRESET_LO) && tone_active && !tone_tick && !tone_start)
            |=> $stable(tone_count_reg);
    endproperty
    a_preset_keeps_count: assert property (p_preset_keeps_count)
        else $error("preset write disturbed the counter");

    property p_toggle;
        tone_uf |=> toggle_reg != $past(toggle_reg);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("tone output did not toggle on underflow");

    property p_stop_pin_high;
        (state_reg == PM_STOP) ##1 (state_reg == PM_STOP)
            |-> o_tone_output_pin;
    endproperty
    a_stop_pin_high: assert property (p_stop_pin_high)
        else $error("tone pin not high in stop");

    property p_stop_wake;
        s_stop_wake |=> (state_reg == PM_RUN) ##1 o_core_run;
    endproperty
    a_stop_wake: assert property (p_stop_wake)
        else $error("enabled falling edge did not leave stop");

    property p_hold_blocked;
        ((state_reg == PM_RUN) && i_instr_hold && !i_instr_stop &&
            hcf_reg != FLAGS_RESET) |=> state_reg == PM_RUN;
    endproperty
    a_hold_blocked: assert property (p_hold_blocked)
        else $error("hold entered while a cause flag was set");

    property p_ack_inhibits;
        (i_irq_ack && !i_irq_enable_instr && !wr(SEL_IRQ_EN_LO) &&
            !wr(SEL_IRQ_EN_HI)) |=> !gie_reg ##1 !o_irq_request;
    endproperty
    a_ack_inhibits: assert property (p_ack_inhibits)
        else $error("interrupt not inhibited after acceptance");

    property p_irq_needs_enable;
        o_irq_request |-> $past(gie_reg) && ($past(evf_reg & ief_reg) != 0);
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt raised without enabled event");

    property p_isr_back_to_hold;
        s_isr_return_idle |=> (state_reg == PM_HOLD) ##1 !o_core_run;
    endproperty
    a_isr_back_to_hold: assert property (p_isr_back_to_hold)
        else $error("return from handler did not re-enter hold");
endmodule

/* include/tone_pkg.sv */
package tone_pkg;

    localparam int DATA_W = 4;
    localparam int SEL_W = 4;
    localparam int COUNT_W = 8;
    localparam int FLAG_W = 8;
    localparam int VEC_W = 12;
    localparam int PIN_W = 4;

    // Write-strobe register selects
    localparam logic [SEL_W-1:0] SEL_INTERVAL_CTRL = 4'h0;
    localparam logic [SEL_W-1:0] SEL_TONE_CTRL = 4'h1;
    localparam logic [SEL_W-1:0] SEL_STOP_WAKE = 4'h2;
    localparam logic [SEL_W-1:0] SEL_HOLD_EN_LO = 4'h3;
    localparam logic [SEL_W-1:0] SEL_HOLD_EN_HI = 4'h4;
    localparam logic [SEL_W-1:0] SEL_IRQ_EN_LO = 4'h5;
    localparam logic [SEL_W-1:0] SEL_IRQ_EN_HI = 4'h6;
    localparam logic [SEL_W-1:0] SEL_PIN_EN = 4'h7;
    localparam logic [SEL_W-1:0] SEL_PRESET_LO = 4'h8;
    localparam logic [SEL_W-1:0] SEL_PRESET_HI = 4'h9;
    localparam logic [SEL_W-1:0] SEL_EVF_CLR_LO = 4'hA;
    localparam logic [SEL_W-1:0] SEL_EVF_CLR_HI = 4'hB;

    // Control register fields
    localparam int TONE_DIV_BIT = 0;
    localparam int TONE_SUB_BIT = 1;
    localparam int TONE_PIN_BIT = 2;
    localparam int RUN_BIT = 3;
    localparam int INTERVAL_DIV_BIT = 0;

    // Event flag positions
    localparam logic [2:0] EV_DIV0 = 3'h0;
    localparam logic [2:0] EV_INTERVAL = 3'h1;
    localparam logic [2:0] EV_PORT = 3'h2;
    localparam logic [2:0] EV_DIV1 = 3'h4;
    localparam logic [2:0] EV_TONE = 3'h7;
    localparam int HCF_TONE_BIT = 5;
    localparam logic [FLAG_W-1:0] EVENT_MASK = 8'h97;

    localparam int PRESCALE_DIV = 64;
    localparam int PRESCALE_W = 6;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
        PRESCALE_W'(PRESCALE_DIV - 1);

    localparam logic [VEC_W-1:0] VEC_DIV0 = 12'h004;
    localparam logic [VEC_W-1:0] VEC_INTERVAL = 12'h008;
    localparam logic [VEC_W-1:0] VEC_PORT = 12'h00C;
    localparam logic [VEC_W-1:0] VEC_DIV1 = 12'h010;
    localparam logic [VEC_W-1:0] VEC_TONE = 12'h020;

    localparam logic [DATA_W-1:0] CTRL_RESET = 4'h0;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 8'h00;

    typedef enum logic [3:0] {
        PM_RUN = 4'b0001,
        PM_HOLD = 4'b0010,
        PM_STOP = 4'b0100,
        PM_HOLD_ISR = 4'b1000
    } power_mode_e;

endpackage

/* rtl/sync2.sv */
module sync2
    import tone_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

/* tb/core_model.sv */
module core_model
    import tone_pkg::*;
(
    input wire logic i_clock,
    output logic o_wr_strobe,
    output logic [SEL_W-1:0] o_wr_sel,
    output logic [DATA_W-1:0] o_wr_data,
    output logic o_stop,
    output logic o_hold,
    output logic o_irq_en,
    output logic o_irq_mask,
    output logic o_ret,
    output logic o_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_wr_strobe = 1'b0;
        o_wr_sel = 4'hF;
        o_wr_data = 4'hF;
        {o_ack, o_ret, o_irq_mask, o_irq_en, o_hold, o_stop} = 6'h00;
    end
    // One-cycle strobe, idle bus inverted
    task automatic write(input logic [SEL_W-1:0] s,
                         input logic [DATA_W-1:0] d);
        @(negedge i_clock);
        o_wr_strobe = 1'b1;
        o_wr_sel = s;
        o_wr_data = d;
        @(negedge i_clock);
        o_wr_strobe = 1'b0;
        o_wr_sel = ~s;
        o_wr_data = ~d;
    endtask
    // Stop gets an idle slot after it
    task automatic instr(input int k);
        @(negedge i_clock);
        {o_ack, o_ret, o_irq_mask, o_irq_en, o_hold, o_stop} = 6'h01 << k;
        @(negedge i_clock);
        {o_ack, o_ret, o_irq_mask, o_irq_en, o_hold, o_stop} = 6'h00;
        if (k == 0)
            @(negedge i_clock);
    endtask
endmodule

/* tb/tb_tone_timer_and_wakeup_control.sv */
module tb_tone_timer_and_wakeup_control
    import tone_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, stb, slow, wave, sub, pin, irq, run, osc, idv, irn;
    logic [3:0] sel, dat, wake;
    logic do_stop, do_hold, do_ien, do_mask, do_ret, do_ack;
    logic ev_div0, ev_div1, ev_ivl;
    logic [11:0] vec;
    logic [7:0] event_flags, hold_cause_flags;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int w, n;
    core_model u_core (.i_clock(clk), .o_wr_strobe(stb), .o_wr_sel(sel),
        .o_wr_data(dat), .o_stop(do_stop), .o_hold(do_hold),
        .o_irq_en(do_ien), .o_irq_mask(do_mask), .o_ret(do_ret),
        .o_ack(do_ack));
    tone_timer_and_wakeup_control u_dut (.i_clock(clk), .i_rst(rst),
        .i_wr_strobe(stb), .i_wr_sel(sel), .i_wr_data(dat),
        .i_instr_stop(do_stop), .i_instr_hold(do_hold),
        .i_irq_enable_instr(do_ien), .i_irq_mask_instr(do_mask),
        .i_return_instr(do_ret), .i_irq_ack(do_ack),
        .i_div0_overflow(ev_div0), .i_div1_overflow(ev_div1),
        .i_interval_underflow(ev_ivl), .i_dual_clock_slow(slow),
        .i_waveform_gen(wave), .i_sub_osc_clock(sub),
        .i_wake_input_port(wake), .o_tone_output_pin(pin),
        .o_irq_request(irq), .o_irq_vector(vec), .o_core_run(run),
        .o_main_osc_enable(osc), .o_interval_clock_div(idv),
        .o_interval_run(irn), .o_event_flags(event_flags),
        .o_hold_cause_flags(hold_cause_flags));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Free-running 32.768 kHz oscillator, phase unrelated
    initial
    begin
        sub = 1'b0;
        #7;
        forever #15259 sub = ~sub;
    end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 60000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("unexpected at %0t: span %0d", $time, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic pulse(input logic [2:0] e);
        @(negedge clk);
        {ev_ivl, ev_div1, ev_div0} = e;
        @(negedge clk);
        {ev_ivl, ev_div1, ev_div0} = 3'h0;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        wake = 4'hF;
        slow = 1'b0;
        wave = 1'b0;
        tick(5);
        rst = 1'b0;
        tick(3);
    endtask
    // Bounded wait for irq (0) or core run (1)
    task automatic wait_hi(input int which);
        int k;
        k = 0;
        while (((which == 0) ? irq : run) !== 1'b1 && k < 200)
        begin
            tick(1);
            k++;
        end
    endtask
    task automatic gap(output int wt, output int len);
        logic p;
        p = pin;
        for (wt = 0; wt < 4000 && pin === p; wt++)
            tick(1);
        p = pin;
        for (len = 0; len < 4000 && pin === p; len++)
            tick(1);
    endtask
    task automatic t_interval();
        do_reset();
        check(run, 1'b1);
        check(event_flags, 8'h00);
        u_core.write(SEL_INTERVAL_CTRL, 4'h9);
        check(idv, 1'b1);
        check(irn, 1'b1);
        u_core.write(SEL_INTERVAL_CTRL, 4'h6);
        check(idv, 1'b0);
        check(irn, 1'b0);
        $display("interval control finished");
    endtask
    task automatic t_tone();
        do_reset();
        u_core.write(SEL_PRESET_LO, 4'h3);
        u_core.write(SEL_PRESET_HI, 4'h0);
        u_core.write(SEL_TONE_CTRL, 4'hC);
        gap(w, n);
        check_range(n, 4, 4);
        check(event_flags[7], 1'b1);
        u_core.write(SEL_PRESET_LO, 4'h7);
        gap(w, n);
        check_range(w, 0, 4);
        check_range(n, 8, 8);
        u_core.write(SEL_TONE_CTRL, 4'hD);
        // Written between slow ticks, so the counter must hold
        u_core.write(SEL_PRESET_LO, 4'h0);
        gap(w, n);
        gap(w, n);
        check_range(n, 64, 64);
        u_core.write(SEL_TONE_CTRL, 4'hE);
        gap(w, n);
        gap(w, n);
        check_range(n, 1524, 1527);
        u_core.write(SEL_TONE_CTRL, 4'h4);
        w = pin;
        tick(20);
        check(pin, w);
        u_core.write(SEL_PRESET_LO, 4'hF);
        u_core.write(SEL_TONE_CTRL, 4'h8);
        check(event_flags[7], 1'b0);
        wave = 1'b1;
        tick(3);
        check(pin, 1'b1);
        wave = 1'b0;
        tick(3);
        check(pin, 1'b0);
        $display("tone timer finished");
    endtask
    task automatic t_irq();
        do_reset();
        u_core.write(SEL_IRQ_EN_HI, 4'h8);
        u_core.write(SEL_PRESET_LO, 4'h3);
        u_core.write(SEL_TONE_CTRL, 4'h8);
        wait_hi(0);
        check(irq, 1'b1);
        check(vec, 12'h020);
        u_core.instr(5);
        check(irq, 1'b0);
        check(event_flags[7], 1'b0);
        tick(12);
        check(irq, 1'b0);
        u_core.instr(2);
        tick(2);
        check(irq, 1'b1);
        u_core.instr(3);
        tick(2);
        check(irq, 1'b0);
        $display("tone interrupt finished");
    endtask
    task automatic t_prio();
        do_reset();
        u_core.write(SEL_IRQ_EN_LO, 4'h3);
        pulse(3'b101);
        wait_hi(0);
        check(vec, 12'h004);
        u_core.instr(5);
        check(event_flags, 8'h02);
        u_core.instr(2);
        wait_hi(0);
        check(vec, 12'h008);
        u_core.instr(5);
        u_core.write(SEL_IRQ_EN_HI, 4'h1);
        pulse(3'b010);
        wait_hi(0);
        check(vec, 12'h010);
        $display("priority finished");
    endtask
    task automatic t_port();
        do_reset();
        u_core.write(SEL_PIN_EN, 4'h1);
        u_core.write(SEL_IRQ_EN_LO, 4'h4);
        wake[1] = 1'b0;
        tick(6);
        check(event_flags, 8'h00);
        wake[0] = 1'b0;
        wait_hi(0);
        check(vec, 12'h00C);
        check(event_flags[2], 1'b1);
        $display("port event finished");
    endtask
    task automatic t_hold();
        do_reset();
        u_core.write(SEL_HOLD_EN_LO, 4'h1);
        u_core.instr(1);
        tick(2);
        check(run, 1'b0);
        pulse(3'b001);
        tick(3);
        check(run, 1'b1);
        check(hold_cause_flags, 8'h01);
        u_core.instr(1);
        tick(3);
        check(run, 1'b1);
        u_core.write(SEL_EVF_CLR_LO, 4'h1);
        check(hold_cause_flags, 8'h00);
        u_core.write(SEL_HOLD_EN_HI, 4'h8);
        u_core.write(SEL_PRESET_LO, 4'hF);
        u_core.write(SEL_TONE_CTRL, 4'h8);
        u_core.instr(1);
        tick(2);
        check(run, 1'b0);
        wait_hi(1);
        check(hold_cause_flags, 8'h20);
        $display("hold release finished");
    endtask
    task automatic t_isr_hold();
        do_reset();
        u_core.write(SEL_IRQ_EN_LO, 4'h1);
        u_core.instr(1);
        tick(2);
        check(run, 1'b0);
        pulse(3'b001);
        wait_hi(1);
        check(run, 1'b1);
        u_core.instr(5);
        u_core.instr(4);
        tick(2);
        check(run, 1'b0);
        $display("interrupt in hold finished");
    endtask
    task automatic t_stop();
        do_reset();
        u_core.write(SEL_STOP_WAKE, 4'h1);
        u_core.write(SEL_TONE_CTRL, 4'h4);
        u_core.instr(0);
        check(run, 1'b0);
        check(pin, 1'b1);
        wake[1] = 1'b0;
        tick(6);
        check(run, 1'b0);
        wake[0] = 1'b0;
        wait_hi(1);
        check(run, 1'b1);
        do_reset();
        slow = 1'b1;
        u_core.write(SEL_STOP_WAKE, 4'h1);
        u_core.instr(0);
        check(osc, 1'b0);
        check(run, 1'b1);
        wake[0] = 1'b0;
        tick(6);
        check(osc, 1'b1);
        $display("stop mode finished");
    endtask
    initial
    begin
        rst = 1'b1;
        {ev_ivl, ev_div1, ev_div0} = 3'h0;
        t_interval();
        t_tone();
        t_irq();
        t_prio();
        t_port();
        t_hold();
        t_isr_hold();
        t_stop();
        give_verdict();
    end
endmodule
